/* File: rtl/pwm_output_override_control.sv */
// Output stage of one PWM channel with overrides, dead time and bus registers
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "pwm_ovr_map.svh"

module pwm_output_override_control (
  input  wire logic                I_CLK,
  input  wire logic                I_RST,
  input  wire pwm_ovr_pkg::ahb_req_t I_AHB,
  output pwm_ovr_pkg::ahb_rsp_t    O_AHB,
  input  wire logic                I_FAULT,
  input  wire logic                I_LIMIT,
  input  wire logic                I_SLEEP,
  input  wire logic                I_IDLE,
  input  wire pwm_ovr_pkg::pins_t  I_GPIO,
  output pwm_ovr_pkg::pins_t       O_PINS,
  output logic                     O_WAKE
);
  import pwm_ovr_pkg::*;

  // Software visible registers
  logic [`CT_W-1:0]   channel_ctrl_reg;         // Mode and enable bits
  logic [`OC_W-1:0]   channel_output_ctrl_reg;  // Override, polarity, ownership
  logic [`FC_W-1:0]   fault_ctrl;               // Fault and limit enables
  logic [15:0]        period;                   // Last count of the cycle
  logic [15:0]        duty_buf;                 // Duty as written
  logic [15:0]        phase;                    // Phase offset
  logic [15:0]        deadtime;                 // Dead time
  // Internal state
  logic [15:0]        timebase_counter;         // Channel time base
  logic [15:0]        duty_act;                 // Duty in use
  logic [1:0]         ovr_en_act;               // Override enables in use
  logic [1:0]         ovr_dat_act;              // Override data in use
  logic               fault_state;              // Fault override held
  logic               limit_state;              // Limit override held
  logic [1:0]         dt_out;                   // Dead-time stage outputs
  // Bus slave state
  logic               wr_pend;                  // Write data phase due
  logic [7:0]         wr_addr;                  // Address of that write
  logic [31:0]        rdata;                    // Read data register

  // Field decode
  wire module_en  = channel_ctrl_reg[`CT_MODULE_EN];
  wire timebase_run = channel_ctrl_reg[`CT_TB_RUN];
  wire compl_mode = channel_ctrl_reg[`CT_COMPL];
  wire immediate_update_en = channel_ctrl_reg[`CT_IUE];
  wire var_phase  = channel_ctrl_reg[`CT_VARPHASE];
  wire idle_stop_sel = channel_ctrl_reg[`CT_IDLE_STOP];
  wire [1:0] manual_override_data =
    {channel_output_ctrl_reg[`OC_MAN_HI], channel_output_ctrl_reg[`OC_MAN_LO]};
  wire [1:0] ovr_en_sw =
    {channel_output_ctrl_reg[`OC_HIGH_OVR_EN], channel_output_ctrl_reg[`OC_LOW_OVR_EN]};
  wire [1:0] fault_override_data =
    {channel_output_ctrl_reg[`OC_FLT_HI], channel_output_ctrl_reg[`OC_FLT_LO]};
  wire [1:0] limit_override_data =
    {channel_output_ctrl_reg[`OC_LIM_HI], channel_output_ctrl_reg[`OC_LIM_LO]};
  wire override_sync_en = channel_output_ctrl_reg[`OC_SYNC_EN];
  wire high_polarity = channel_output_ctrl_reg[`OC_HIGH_POL];
  wire low_polarity  = channel_output_ctrl_reg[`OC_LOW_POL];
  wire [1:0] pin_owner_select =
    {channel_output_ctrl_reg[`OC_HIGH_OWNER], channel_output_ctrl_reg[`OC_LOW_OWNER]};
  wire fault_en = fault_ctrl[`FC_FAULT_EN];
  wire limit_en = fault_ctrl[`FC_LIMIT_EN];

  // Bus address phase accepted
  wire        bus_take = I_AHB.hsel & I_AHB.htrans[1] & I_AHB.hready;
  wire [7:0]  rd_addr  = I_AHB.haddr[7:0];
  wire        wr_ctrl  = wr_pend & (wr_addr == `OFF_CTRL);
  wire        wr_per   = wr_pend & (wr_addr == `OFF_PERIOD);
  wire        wr_duty  = wr_pend & (wr_addr == `OFF_DUTY);
  wire        wr_ph    = wr_pend & (wr_addr == `OFF_PHASE);
  wire        wr_dt    = wr_pend & (wr_addr == `OFF_DEADTIME);
  wire        wr_oc    = wr_pend & (wr_addr == `OFF_OUTCTRL);
  wire        wr_fc    = wr_pend & (wr_addr == `OFF_FLTCTRL);
  wire [15:0] wtime    = I_AHB.hwdata[15:0] & `TIME_MASK;

  // Module stop in sleep or stopped idle
  wire stopped = I_SLEEP | (I_IDLE & idle_stop_sel);
  wire tb_run  = timebase_run & module_en & ~stopped;
  wire tb_zero = (timebase_counter == 16'h0000);
  wire cycle_start = tb_run & tb_zero;

  // Live pin conditions, fault outranks limit
  wire flt_live = fault_en & I_FAULT;
  wire lim_live = limit_en & I_LIMIT;
  wire flt_on   = fault_state | flt_live;
  wire lim_on   = limit_state | lim_live;

  // Status word seen by software
  wire [`ST_W-1:0] status = {stopped, I_LIMIT, I_FAULT, limit_state, fault_state};

  // Read multiplexer, unused bits and addresses give zero
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (rd_addr)
      `OFF_CTRL:     next_rdata[`CT_W-1:0] = channel_ctrl_reg;
      `OFF_PERIOD:   next_rdata[15:0] = period;
      `OFF_DUTY:     next_rdata[15:0] = duty_buf;
      `OFF_PHASE:    next_rdata[15:0] = phase;
      `OFF_DEADTIME: next_rdata[15:0] = deadtime;
      `OFF_OUTCTRL:  next_rdata[`OC_W-1:0] = channel_output_ctrl_reg;
      `OFF_FLTCTRL:  next_rdata[`FC_W-1:0] = fault_ctrl;
      `OFF_STATUS:   next_rdata[`ST_W-1:0] = status;
      `OFF_COUNTER:  next_rdata[15:0] = timebase_counter;
      default:       next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  // Write data trails its address by a cycle, so the address is kept
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rdata   <= 32'h0000_0000;
    end else begin
      wr_pend <= bus_take & I_AHB.hwrite;
      if (bus_take) begin
        wr_addr <= rd_addr;
      end
      if (bus_take & ~I_AHB.hwrite) begin
        rdata <= next_rdata;
      end
    end
  end

  assign O_AHB.hrdata    = rdata;
  assign O_AHB.hreadyout = 1'b1;
  assign O_AHB.hresp     = 1'b0;

  // Register writes, all returned to reset values on reset
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      channel_ctrl_reg        <= `RST_CTRL;
      channel_output_ctrl_reg <= `RST_OUTCTRL;
      fault_ctrl              <= `RST_FLTCTRL;
      period                  <= `RST_TIME;
      duty_buf                <= `RST_TIME;
      phase                   <= `RST_TIME;
      deadtime                <= `RST_TIME;
    end else begin
      if (wr_ctrl) channel_ctrl_reg <= I_AHB.hwdata[`CT_W-1:0];
      if (wr_oc)   channel_output_ctrl_reg <= I_AHB.hwdata[`OC_W-1:0];
      if (wr_fc)   fault_ctrl <= I_AHB.hwdata[`FC_W-1:0];
      if (wr_per)  period <= wtime;
      if (wr_duty) duty_buf <= wtime;
      if (wr_ph)   phase <= wtime;
      if (wr_dt)   deadtime <= wtime;
    end
  end

  // Time base: steps one aligned unit per instruction cycle
  // Held at zero while disabled or not running, so a restart opens a fresh cycle; a sleep or idle stop freezes the count
  wire [15:0] next_counter = (timebase_counter >= period) ? 16'h0000
                           : timebase_counter + `TB_STEP;
  always_ff @(posedge I_CLK) begin
    if (I_RST | ~module_en | ~timebase_run) begin
      timebase_counter <= 16'h0000;
    end else if (tb_run) begin
      timebase_counter <= next_counter;
    end
  end

  // Duty in use: cycle start, or at once when immediate or stopped
  wire duty_take = immediate_update_en | cycle_start | ~tb_run;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      duty_act <= `RST_TIME;
    end else if (duty_take) begin
      duty_act <= duty_buf;
    end
  end

  // Overrides in use: deferred to time base zero when synchronised and running
  wire ovr_take = ~override_sync_en | ~tb_run | cycle_start;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ovr_en_act  <= 2'b00;
      ovr_dat_act <= 2'b00;
    end else if (ovr_take) begin
      ovr_en_act  <= ovr_en_sw;
      ovr_dat_act <= manual_override_data;
    end
  end

  // Fault and limit hold: exit only at cycle start, or at once when stopped
  // Set wins: an event in the exit cycle keeps the hold
  wire exit_ok = ~tb_run | cycle_start;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      fault_state <= 1'b0;
      limit_state <= 1'b0;
    end else begin
      fault_state <= flt_live | (fault_state & ~exit_ok);
      limit_state <= lim_live | (limit_state & ~exit_ok);
    end
  end

  // Generator with phase offset and variable-phase half duty
  wire [16:0] cyc_len  = {1'b0, period} + `TB_STEP17;
  wire [16:0] raw_pos  = {1'b0, timebase_counter} + {1'b0, phase};
  wire [16:0] wrap_pos = (raw_pos >= cyc_len) ? raw_pos - cyc_len : raw_pos;
  wire [15:0] half_per = {1'b0, period[15:1]} & `TIME_MASK;
  wire [15:0] duty_eff = var_phase ? half_per : duty_act;
  wire        gen_high = tb_run & (wrap_pos[15:0] < duty_eff);
  wire        gen_low  = tb_run & compl_mode & ~gen_high;
  wire [1:0]  gen_req  = {gen_high, gen_low};

  // Request chain, lowest priority first, gated before dead time
  wire [1:0] man_req = (ovr_en_act & ovr_dat_act) | (~ovr_en_act & gen_req);
  wire [1:0] lim_req = lim_on ? limit_override_data : man_req;
  wire [1:0] dt_req  = flt_on ? fault_override_data : lim_req;

  // Dead time in whole cycles, only in complementary mode
  wire [12:0] dt_limit = compl_mode ? deadtime[15:`TIME_LSB_BIT] : 13'h0000;

  // Each output asserts only after its request stood for the dead time
  // A dropped request clears at once, so deassertion never waits
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dt
      logic [12:0] dt_cnt; // Cycles the request has stood
      always_ff @(posedge I_CLK) begin
        if (I_RST | ~dt_req[gi]) begin
          dt_cnt     <= 13'h0000;
          dt_out[gi] <= 1'b0;
        end else if (dt_cnt >= dt_limit) begin
          dt_out[gi] <= 1'b1;
        end else begin
          dt_cnt <= dt_cnt + 13'h0001;
        end
      end
    end
  endgenerate

  // Second gate at the pins: deassert data acts without a clock
  // No flop on this path, so a fault reaches the pins within the cycle
  wire [1:0] kill  = ({2{flt_live}} & ~fault_override_data)
                   | ({2{lim_live & ~flt_live}} & ~limit_override_data);
  wire [1:0] level = dt_out & ~kill;
  wire [1:0] pwm_own = {2{module_en}} & ~pin_owner_select;

  // Pin drive, floated while reset is held
  assign O_PINS.high_out = pwm_own[1] ? (level[1] ^ high_polarity) : I_GPIO.high_out;
  assign O_PINS.low_out  = pwm_own[0] ? (level[0] ^ low_polarity) : I_GPIO.low_out;
  assign O_PINS.high_oe  = ~I_RST & (pwm_own[1] | I_GPIO.high_oe);
  assign O_PINS.low_oe   = ~I_RST & (pwm_own[0] | I_GPIO.low_oe);

  // Wake request while stopped, no clock needed
  assign O_WAKE = stopped & fault_en & ~I_FAULT;

  // Checks on the block's own behaviour
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  // Disabled module: pins follow GPIO
  AST_DISABLED_GPIO: assert property (
    !module_en |-> (O_PINS.high_out == I_GPIO.high_out) && (O_PINS.low_oe == I_GPIO.low_oe))
    else $error("disabled module does not hand pins to GPIO");

  // Live fault with low data forces inactive level on the same cycle
  AST_FAULT_KILL: assert property (
    flt_live && !fault_override_data[1] && pwm_own[1] |-> O_PINS.high_out == high_polarity)
    else $error("fault did not deassert high output at once");

  // Asserted request never reaches the pin on its first cycle
  AST_ASSERT_DELAYED: assert property (
    $rose(dt_req[1]) |-> !dt_out[1] ##1 dt_out[1] || compl_mode)
    else $error("asserted override bypassed dead-time delay");

  // Fault outranks limit and manual overrides
  AST_FAULT_PRIORITY: assert property (
    flt_on |-> dt_req == fault_override_data)
    else $error("fault data not selected over lower overrides");

  // Reset owner bits give pins to the module
  AST_OWNER_DEFAULT: assert property (
    module_en && pin_owner_select == 2'b00 |-> O_PINS.high_oe && O_PINS.low_oe)
    else $error("module does not drive pins with default ownership");

  // Synchronised overrides hold away from time base zero
  AST_SYNC_DEFER: assert property (
    override_sync_en && tb_run && !tb_zero |=> $stable(ovr_en_act) && $stable(ovr_dat_act))
    else $error("synchronised override changed away from zero");

  // Write with stopped time base lands one cycle later
  sequence s_stopped_write;
    !tb_run && wr_oc ##1 !tb_run;
  endsequence
  AST_STOPPED_WRITE: assert property (
    s_stopped_write |=> ovr_en_act == $past(ovr_en_sw))
    else $error("output control write not applied next cycle");

  // Held fault survives until cycle start
  AST_FAULT_HOLD: assert property (
    fault_state && tb_run && !tb_zero |=> fault_state)
    else $error("fault released before cycle start");

  // Immediate update copies the written duty next cycle
  AST_IMMEDIATE: assert property (
    immediate_update_en |=> duty_act == $past(duty_buf))
    else $error("immediate update did not apply duty");

  // Falling fault pin while stopped wakes at once
  AST_WAKE: assert property (
    $fell(I_FAULT) && stopped && fault_en |-> O_WAKE)
    else $error("no wake request on fault low in sleep");

  // Unused upper read bits are zero
  AST_READ_ZERO: assert property (
    $past(bus_take) && !$past(I_AHB.hwrite) |-> O_AHB.hrdata[31:16] == 16'h0000
                                               && O_AHB.hrdata[2:0] == 3'h0
                                               || $past(rd_addr) == `OFF_OUTCTRL
                                               || $past(rd_addr) == `OFF_CTRL
                                               || $past(rd_addr) == `OFF_STATUS
                                               || $past(rd_addr) == `OFF_FLTCTRL)
    else $error("unused register bits read nonzero");

  // Variable phase duty is half the period
  AST_VAR_PHASE: assert property (
    var_phase && tb_run && wrap_pos[15:0] < half_per |-> gen_high)
    else $error("variable phase output not high in first half");

  // Live limit with low data forces inactive level when no fault
  AST_LIMIT_KILL: assert property (
    lim_live && !flt_live && !limit_override_data[0] && pwm_own[0]
      |-> O_PINS.low_out == low_polarity)
    else $error("limit did not deassert low output at once");

  // Limit data set to active drives the pin active
  AST_LIMIT_ASSERT: assert property (
    lim_live && !flt_live && limit_override_data[1] && dt_out[1] && pwm_own[1]
      |-> O_PINS.high_out == !high_polarity)
    else $error("limit data did not assert high output");

  // Complementary mode holds a new request back for the dead time
  AST_DT_COMPL: assert property (
    compl_mode && dt_limit != 13'h0000 && $rose(dt_req[1]) |=> !dt_out[1])
    else $error("complementary request skipped dead time");

  // Ended fault clears at the exit point
  AST_FAULT_EXIT: assert property (
    fault_state && !flt_live && exit_ok |=> !fault_state)
    else $error("fault hold not released at exit point");

  // No override active: generator request reaches dead time
  AST_GEN_PASS: assert property (
    !flt_on && !lim_on && ovr_en_act == 2'b00 |-> dt_req == gen_req)
    else $error("generator request altered without override");

  // Owner bit outranks every override
  AST_PIN_OWNER: assert property (
    module_en && pin_owner_select[1] |-> O_PINS.high_out == I_GPIO.high_out
                                         && O_PINS.high_oe == I_GPIO.high_oe)
    else $error("owner bit did not hand high pin to GPIO");

endmodule : pwm_output_override_control

/* File: rtl/pwm_ovr_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef PWM_OVR_MAP_SVH
`define PWM_OVR_MAP_SVH

// Byte offsets of the registers on the bus
`define OFF_CTRL        8'h00
`define OFF_PERIOD      8'h04
`define OFF_DUTY        8'h08
`define OFF_PHASE       8'h0c
`define OFF_DEADTIME    8'h10
`define OFF_OUTCTRL     8'h14
`define OFF_FLTCTRL     8'h18
`define OFF_STATUS      8'h1c
`define OFF_COUNTER     8'h20

// Channel control register fields
`define CT_MODULE_EN    0
`define CT_TB_RUN       1
`define CT_COMPL        2
`define CT_IUE          3
`define CT_VARPHASE     4
`define CT_IDLE_STOP    5
`define CT_W            6

// Output control register fields
`define OC_MAN_LO       0
`define OC_MAN_HI       1
`define OC_LOW_OVR_EN   2
`define OC_HIGH_OVR_EN  3
`define OC_FLT_LO       4
`define OC_FLT_HI       5
`define OC_LIM_LO       6
`define OC_LIM_HI       7
`define OC_SYNC_EN      8
`define OC_LOW_POL      9
`define OC_HIGH_POL     10
`define OC_LOW_OWNER    11
`define OC_HIGH_OWNER   12
`define OC_W            13

// Fault control register fields
`define FC_FAULT_EN     0
`define FC_LIMIT_EN     1
`define FC_W            2

// Status register fields
`define ST_FAULT_STATE  0
`define ST_LIMIT_STATE  1
`define ST_FAULT_PIN    2
`define ST_LIMIT_PIN    3
`define ST_STOPPED      4
`define ST_W            5

// Reset values
`define RST_CTRL        6'h00
`define RST_OUTCTRL     13'h0000
`define RST_FLTCTRL     2'h0
`define RST_TIME        16'h0000

// Time data is aligned so bit 3 is one instruction cycle
`define TIME_LSB_BIT    3
`define TIME_MASK       16'hfff8
`define TB_STEP         16'h0008
`define TB_STEP17       17'h00008
`define TIME_W          16

`endif

/* File: rtl/pwm_ovr_pkg.sv */
// Types shared by the output override block
package pwm_ovr_pkg;

  // AHB-Lite request seen by the slave
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_t;

  // AHB-Lite slave answer
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;

  // One pair of PWM pins, level and enable each
  typedef struct packed {
    logic high_out;
    logic high_oe;
    logic low_out;
    logic low_oe;
  } pins_t;

endpackage : pwm_ovr_pkg

/* File: verification/gate_drv_model.sv */
// Gate driver model fed by the two PWM pins
`timescale 1ns/10ps
module gate_drv_model (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire pwm_ovr_pkg::pins_t i_pins,
  output logic                    o_gate_hi,
  output logic                    o_gate_lo,
  output logic [15:0]             o_overlap
);
  import pwm_ovr_pkg::*;
  // Undriven pin falls to the driver's pull-down
  assign o_gate_hi = i_pins.high_oe ? i_pins.high_out : 1'b0;
  assign o_gate_lo = i_pins.low_oe ? i_pins.low_out : 1'b0;
  // Count cycles with both gates on, a shoot-through hazard
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_overlap <= 16'h0000;
    end else if (o_gate_hi && o_gate_lo) begin
      o_overlap <= o_overlap + 16'h0001;
    end
  end
endmodule : gate_drv_model

/* File: verification/tb.sv */
// Self-checking bench for the PWM output override block
`timescale 1ns/10ps
`include "pwm_ovr_map.svh"
module tb;
  import pwm_ovr_pkg::*;
  logic        i_clk, i_rst;          // Clock and reset
  logic        hsel, hwrite;          // Bus request fields
  logic [31:0] haddr, hwdata;         // Bus address and write data
  logic [1:0]  htrans;                // Transfer kind
  logic [2:0]  hsize;                 // Always a word
  logic        i_fault, i_limit;      // Event inputs
  logic        i_sleep, i_idle;       // Power-state inputs
  pins_t       gpio, pins;            // GPIO side and pin outputs
  ahb_rsp_t    rsp;                   // Bus answer
  ahb_req_t    req;                   // Bus request bundle
  logic        wake, g_hi, g_lo;      // Wake request, gate levels
  logic [15:0] ovl, ov0;              // Overlap counts
  logic [31:0] rd;                    // Last read data
  int          n;                     // Wait length
  int          fails, cmp_count;      // Mismatch and comparison counts
  // Bundle the request; hready follows the only slave
  assign req = '{hsel, haddr, htrans, hwrite, hsize, hwdata, rsp.hreadyout};
  pwm_output_override_control DUT (
    .I_CLK  (i_clk),
    .I_RST  (i_rst),
    .I_AHB  (req),
    .O_AHB  (rsp),
    .I_FAULT(i_fault),
    .I_LIMIT(i_limit),
    .I_SLEEP(i_sleep),
    .I_IDLE (i_idle),
    .I_GPIO (gpio),
    .O_PINS (pins),
    .O_WAKE (wake)
  );
  gate_drv_model drv (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_pins   (pins),
    .o_gate_hi(g_hi),
    .o_gate_lo(g_lo),
    .o_overlap(ovl)
  );
  // 100 ns clock
  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Pin bundle compare: high_out, high_oe, low_out, low_oe
  task pchk(input logic [3:0] exp);
    chk({28'h0000000, pins}, {28'h0000000, exp});
  endtask : pchk
  // Let k edges pass, then settle
  task cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : cyc
  // One single AHB-Lite transfer, address then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge i_clk); while (rsp.hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge i_clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rchk
  // Wait, bounded, until the pins show a pattern
  task wait_pins(input logic [3:0] exp);
    n = 0;
    while (pins !== exp && n < 4200) begin
      cyc(1);
      n++;
    end
  endtask : wait_pins
  // Reset body: pins float, registers clear, holes read zero
  task rst_body;
    cyc(1);
    chk({30'h0, pins.high_oe, pins.low_oe}, 32'h0);
    @(posedge i_clk);
    i_rst <= 1'b0;
    rchk(`OFF_CTRL, 32'h0);
    rchk(`OFF_OUTCTRL, 32'h0);
    rchk(`OFF_DUTY, 32'h0);
    rchk(8'h40, 32'h0);
  endtask : rst_body
  // Time alignment and unused bits; disabled module gives pins to GPIO
  task t_regs;
    wr(`OFF_PERIOD, 32'hffffffff);
    rchk(`OFF_PERIOD, 32'h0000fff8);
    wr(`OFF_FLTCTRL, 32'hffffffff);
    rchk(`OFF_FLTCTRL, 32'h3);
    wr(`OFF_FLTCTRL, 32'h0);
    gpio <= 4'b1011;
    cyc(2);
    pchk(4'b1011);
  endtask : t_regs
  // Generator output, manual overrides, polarity, stopped-base writes
  task t_manual;
    wr(`OFF_PERIOD, 32'h7ff8);
    wr(`OFF_CTRL, 32'h0b);
    cyc(3);
    pchk(4'b0101);
    wr(`OFF_DUTY, 32'hfff8);
    cyc(3);
    pchk(4'b1101);
    wr(`OFF_CTRL, 32'h09);
    wr(`OFF_OUTCTRL, 32'h10d);
    cyc(3);
    pchk(4'b0111);
    wr(`OFF_OUTCTRL, 32'h40d);
    cyc(3);
    pchk(4'b1111);
  endtask : t_manual
  // Priority of fault over limit and manual, owner above all
  task t_fault;
    wr(`OFF_OUTCTRL, 32'hcf);
    wr(`OFF_FLTCTRL, 32'h3);
    cyc(3);
    pchk(4'b1111);
    @(posedge i_clk);
    i_fault <= 1'b1;
    i_limit <= 1'b1;
    #1;
    pchk(4'b0101);
    @(posedge i_clk);
    i_fault <= 1'b0;
    i_limit <= 1'b0;
    cyc(3);
    pchk(4'b1111);
    wr(`OFF_OUTCTRL, 32'h18cf);
    @(posedge i_clk);
    i_fault <= 1'b1;
    cyc(2);
    pchk(4'b1011);
    @(posedge i_clk);
    i_fault <= 1'b0;
  endtask : t_fault
  // Asserting fault data in complementary mode waits for dead time
  task t_compl;
    wr(`OFF_DUTY, 32'h0);
    wr(`OFF_DEADTIME, 32'h20);
    wr(`OFF_OUTCTRL, 32'h20);
    wr(`OFF_FLTCTRL, 32'h1);
    wr(`OFF_CTRL, 32'h0d);
    cyc(10);
    ov0 = ovl;
    @(posedge i_clk);
    i_fault <= 1'b1;
    #1;
    pchk(4'b0101);
    cyc(1);
    chk({g_hi, g_lo}, 2'b00);
    cyc(3);
    pchk(4'b0101);
    cyc(5);
    pchk(4'b1101);
    chk(ovl, ov0);
    @(posedge i_clk);
    i_fault <= 1'b0;
  endtask : t_compl
  // Limit data asserting pins, fault exit and synchronised overrides
  task t_run;
    wr(`OFF_CTRL, 32'h09);
    wr(`OFF_OUTCTRL, 32'h0f);
    wr(`OFF_FLTCTRL, 32'h2);
    @(posedge i_clk);
    i_limit <= 1'b1;
    #1;
    pchk(4'b0101);
    @(posedge i_clk);
    i_limit <= 1'b0;
    wr(`OFF_OUTCTRL, 32'hc0);
    @(posedge i_clk);
    i_limit <= 1'b1;
    cyc(3);
    pchk(4'b1111);
    @(posedge i_clk);
    i_limit <= 1'b0;
    wr(`OFF_PERIOD, 32'h7ff8);
    wr(`OFF_OUTCTRL, 32'h0f);
    wr(`OFF_FLTCTRL, 32'h1);
    wr(`OFF_CTRL, 32'h0b);
    @(posedge i_clk);
    i_fault <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_fault <= 1'b0;
    cyc(3);
    pchk(4'b0101);
    wait_pins(4'b1111);
    chk({31'h0, n > 3000 && n < 4200}, 32'h1);
    wr(`OFF_OUTCTRL, 32'h10c);
    cyc(3);
    pchk(4'b1111);
    wait_pins(4'b0101);
    chk({31'h0, n > 3000 && n < 4200}, 32'h1);
  endtask : t_run
  // Wake request in sleep and in stopped idle
  task t_sleep;
    wr(`OFF_CTRL, 32'h01);
    wr(`OFF_OUTCTRL, 32'h1800);
    @(posedge i_clk);
    i_sleep <= 1'b1;
    cyc(1);
    chk(wake, 1'b1);
    @(posedge i_clk);
    i_sleep <= 1'b0;
    i_idle  <= 1'b1;
    cyc(1);
    chk(wake, 1'b0);
    wr(`OFF_CTRL, 32'h21);
    cyc(1);
    chk(wake, 1'b1);
    rchk(`OFF_STATUS, 32'h10);
    i_fault <= 1'b1;
    #1;
    chk(wake, 1'b0);
    @(posedge i_clk);
    i_fault <= 1'b0;
    i_idle  <= 1'b0;
  endtask : t_sleep
  // Report counts and verdict, then stop
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // Watchdog well beyond the expected 8.4k cycles
  initial begin
    #3000000;
    fails++;
    end_sim();
  end
  // Main sequence
  initial begin
    i_rst   = 1'b1;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0;
    i_fault = 1'b0;
    i_limit = 1'b0;
    i_sleep = 1'b0;
    i_idle  = 1'b0;
    gpio    = 4'b0000;
    fails   = 0;
    cmp_count = 0;
    rst_body();
    t_regs();
    t_manual();
    t_fault();
    t_compl();
    t_run();
    t_sleep();
    gpio <= 4'b1111;
    @(posedge i_clk);
    i_rst <= 1'b1;
    rst_body();
    end_sim();
  end
endmodule : tb
